/* shared/mmc_pkg.sv */
// Constants, mode type and pointer helpers for the magnetometer
// measurement control block.
// Assumes a single 100 MHz core clock; no timescale needed here.
package mmc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Shortest measurement period (fastest output rate)
  localparam int unsigned MEAS_MIN_NS   = 12_500_000;
  localparam int unsigned MEAS_MIN_CYC  =
    (MEAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 8;
  localparam int SAMPLE_W = 16;
  localparam int OFFSET_W = 15;
  localparam int RATE_W   = 5;
  localparam int CNT_W    = 32;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_FLAGS      = 8'h00;
  localparam logic [7:0] ADDR_X_HIGH     = 8'h01;
  localparam logic [7:0] ADDR_X_LOW      = 8'h02;
  localparam logic [7:0] ADDR_Y_HIGH     = 8'h03;
  localparam logic [7:0] ADDR_Y_LOW      = 8'h04;
  localparam logic [7:0] ADDR_Z_HIGH     = 8'h05;
  localparam logic [7:0] ADDR_Z_LOW      = 8'h06;
  localparam logic [7:0] ADDR_IDENTITY   = 8'h07;
  localparam logic [7:0] ADDR_OPSTATE    = 8'h08;
  localparam logic [7:0] ADDR_X_OFF_HIGH = 8'h09;
  localparam logic [7:0] ADDR_X_OFF_LOW  = 8'h0a;
  localparam logic [7:0] ADDR_Y_OFF_HIGH = 8'h0b;
  localparam logic [7:0] ADDR_Y_OFF_LOW  = 8'h0c;
  localparam logic [7:0] ADDR_Z_OFF_HIGH = 8'h0d;
  localparam logic [7:0] ADDR_Z_OFF_LOW  = 8'h0e;
  localparam logic [7:0] ADDR_TEMP       = 8'h0f;
  localparam logic [7:0] ADDR_ACQ_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_CORR_CTRL  = 8'h11;
  localparam logic [7:0] ADDR_LAST       = ADDR_CORR_CTRL;

  localparam logic [7:0] RESET_BYTE      = 8'h00;
  localparam logic [7:0] UNMAPPED_BYTE   = 8'h00;
  localparam logic [7:0] STEP_NORMAL     = 8'h01;
  localparam logic [7:0] STEP_FAST       = 8'h02;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CR1_ACTIVE    = 0;
  localparam int CR1_TRIGGER   = 1;
  localparam int CR1_FAST_READ = 2;
  localparam int CR1_RATE_LSB  = 3;
  localparam int CR2_RAW       = 5;
  localparam int CR2_AUTO_RST  = 7;

  localparam int FLG_X_NEW  = 0;
  localparam int FLG_Y_NEW  = 1;
  localparam int FLG_Z_NEW  = 2;
  localparam int FLG_ALL_NEW = 3;
  localparam int FLG_X_OVR  = 4;
  localparam int FLG_Y_OVR  = 5;
  localparam int FLG_Z_OVR  = 6;
  localparam int FLG_ALL_OVR = 7;

  localparam int OFF_HIGH_LSB = 7;
  localparam int OFF_LOW_W    = 7;

  typedef enum logic [1:0] {
    MMC_STANDBY,
    MMC_SINGLE,
    MMC_CONT
  } mmc_mode_t;

  // Register pointer after one byte; fast read skips the X, Y and Z sample low bytes
  function automatic logic [7:0] mmc_next_ptr(input logic [7:0] ptr,
                                               input logic       fast);
    if (ptr == ADDR_LAST)
      return ADDR_FLAGS;
    if (fast && (ptr == ADDR_X_HIGH || ptr == ADDR_Y_HIGH ||
                 ptr == ADDR_Z_HIGH))
      return ptr + STEP_FAST;
    return ptr + STEP_NORMAL;
  endfunction

  function automatic mmc_mode_t mmc_decode_mode(input logic [7:0] c1);
    if (c1[CR1_ACTIVE])
      return MMC_CONT;
    if (c1[CR1_TRIGGER])
      return MMC_SINGLE;
    return MMC_STANDBY;
  endfunction

endpackage

/* rtl/mmc_meas_timer.sv */
// Measurement period timer: paces acquisitions while running.
// Assumes run and the rate inputs come from registers on core_clk.
`timescale 1ns/1ps
module mmc_meas_timer #(
  parameter int unsigned BASE_CYC = mmc_pkg::MEAS_MIN_CYC
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  // Control
  input  wire logic                      run,
  input  wire logic                      fast,
  input  wire logic [mmc_pkg::RATE_W-1:0] rate_sel,
  // Events
  output logic                           meas_start,
  output logic                           meas_done
);
  import mmc_pkg::*;

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] cnt;
  } mmc_timer_st_t;

  mmc_timer_st_t    st_reg;
  mmc_timer_st_t    st_next;
  logic [CNT_W-1:0] period;

  // ****************************************************************
  // Period: fast finish uses the shortest period
  // ****************************************************************
  always_comb begin
    if (fast)
      period = CNT_W'(BASE_CYC);
    else
      period = CNT_W'(BASE_CYC) * (CNT_W'(rate_sel) + CNT_W'(1));
  end

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    meas_start   = 1'b0;
    if (!run) begin
      st_next.busy = 1'b0;
      st_next.cnt  = '0;
    end else if (!st_reg.busy) begin
      st_next.busy = 1'b1;
      st_next.cnt  = '0;
      meas_start   = 1'b1;
    end else if (st_reg.cnt >= period - CNT_W'(1)) begin
      st_next.busy = 1'b0;
      st_next.done = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign meas_done = st_reg.done;

  // ****************************************************************
  // Checks
  // ****************************************************************
  cont_restart_a: // see [R6]
    assert property (@(posedge core_clk) disable iff (reset)
      st_reg.done && run |-> meas_start)
    else $error("continuous run did not restart a measurement");

  fast_finish_a: // see [R7]
    assert property (@(posedge core_clk) disable iff (reset)
      run && fast && st_reg.busy && st_reg.cnt >= CNT_W'(BASE_CYC) - 1
      |=> st_reg.done)
    else $error("fast finish did not end the measurement");

endmodule // mmc_meas_timer

/* rtl/mmc_measure_control.sv */
// Measurement control and register map of a three-axis magnetometer.
// Assumes a neighbouring serial front end turns bus frames into
// pointer loads and byte read and write strobes on core_clk.
`timescale 1ns/1ps

// Behaviour
// [R1] Interrupt follows the all-axes new-data flag
// [R2] Reading X high byte drops interrupt
// [R3] Host reads 0x01..0x06 then waits
// [R4] Both run bits clear: standby, no acquisition
// [R5] Trigger only: one measurement, then standby
// [R6] Active only: continuous acquisition at rate
// [R7] Both set: finish fast, then resume rate
// [R8] Auto sensor reset enable is control2 bit7
// [R9] Value 0x01 selects active, fastest rate
// [R10] Value 0xC9 selects active, slow rate
// [R11] Value 0b00011010 starts one triggered measurement
// [R12] Pointer steps one; fast read skips lows
// [R13] Read-only registers keep contents in standby
// [R14] Control writable only in standby, except run
// [R15] Flags, offsets, controls reset to zero
// [R16] Sample high byte 15:8, low 7:0
// [R17] Offset high holds 14:7, low 6:0
// [R18] Temperature is signed eight-bit Celsius
// [R19] Combined flag clears after all high reads
// [R20] Other sample bytes refresh after 0x01 read
// [R21] Fast read is control1 bit2
// [R22] Interrupt is a level, not pulse
// [R23] Protected control writes outside standby ignored
module mmc_measure_control #(
  parameter int unsigned BASE_CYC = mmc_pkg::MEAS_MIN_CYC,
  // Identity value is arbitrary
  parameter logic [7:0]  PART_ID  = 8'h5a
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  // Register access
  input  wire logic                        ptr_load,
  input  wire logic [mmc_pkg::ADDR_W-1:0]  ptr_addr,
  input  wire logic                        rd_req,
  output logic      [mmc_pkg::DATA_W-1:0]  rd_data,
  input  wire logic                        wr_req,
  input  wire logic [mmc_pkg::DATA_W-1:0]  wr_data,
  // Sensor front end
  input  wire logic [mmc_pkg::SAMPLE_W-1:0] x_field,
  input  wire logic [mmc_pkg::SAMPLE_W-1:0] y_field,
  input  wire logic [mmc_pkg::SAMPLE_W-1:0] z_field,
  input  wire logic [mmc_pkg::DATA_W-1:0]  temp_field,
  output logic                             sensor_reset_pulse,
  // Interrupt
  output logic                             new_sample_irq
);
  import mmc_pkg::*;

  typedef struct packed {
    logic [ADDR_W-1:0]   ptr;
    logic [DATA_W-1:0]   rd_data;
    logic [DATA_W-1:0]   ctrl1;
    logic [DATA_W-1:0]   ctrl2;
    logic [OFFSET_W-1:0] off_x;
    logic [OFFSET_W-1:0] off_y;
    logic [OFFSET_W-1:0] off_z;
    logic [DATA_W-1:0]   flags;
    logic                irq;
    logic                sensor_rst;
    logic [SAMPLE_W-1:0] xs;
    logic [SAMPLE_W-1:0] ys;
    logic [SAMPLE_W-1:0] zs;
    logic [SAMPLE_W-1:0] sx;
    logic [SAMPLE_W-1:0] sy;
    logic [SAMPLE_W-1:0] sz;
    logic [DATA_W-1:0]   temp;
    mmc_mode_t           mode;
  } mmc_ctrl_st_t;

  mmc_ctrl_st_t      st_reg;
  mmc_ctrl_st_t      st_next;
  logic              meas_start;
  logic              meas_done;
  logic              run;
  logic              fast_finish;
  logic              standby;
  logic              rd_en;
  logic              wr_en;
  logic              read_x;
  logic              read_y;
  logic              read_z;
  logic              ctrl1_wr;
  logic [DATA_W-1:0] rd_mux;

  // Offset-corrected sample unless raw output is selected
  function automatic logic [SAMPLE_W-1:0] corrected(
    input logic [SAMPLE_W-1:0] field,
    input logic [OFFSET_W-1:0] off,
    input logic                raw);
    if (raw)
      return field;
    return SAMPLE_W'(field + {off[OFFSET_W-1], off});
  endfunction

  function automatic logic [DATA_W-1:0] off_low(
    input logic [OFFSET_W-1:0] off);
    return {off[OFF_LOW_W-1:0], 1'b0};
  endfunction

  // ****************************************************************
  // Measurement pacing
  // ****************************************************************
  // A finished single shot must not start another measurement
  assign run         = st_reg.ctrl1[CR1_ACTIVE] |
                       (st_reg.ctrl1[CR1_TRIGGER] & !meas_done); // see [R5]
  assign fast_finish = st_reg.ctrl1[CR1_ACTIVE] & st_reg.ctrl1[CR1_TRIGGER];

  mmc_meas_timer #(
    .BASE_CYC (BASE_CYC)
  ) u_timer (
    .core_clk   (core_clk),
    .reset      (reset),
    .run        (run),                               // see [R4]
    .fast       (fast_finish),                       // see [R7]
    .rate_sel   (st_reg.ctrl1[CR1_RATE_LSB +: RATE_W]), // see [R9] [R10]
    .meas_start (meas_start),
    .meas_done  (meas_done)
  );

  // ****************************************************************
  // Read decode
  // ****************************************************************
  always_comb begin
    unique case (st_reg.ptr)
      ADDR_FLAGS:      rd_mux = st_reg.flags;
      ADDR_X_HIGH:     rd_mux = st_reg.xs[15:8];  // see [R16]
      ADDR_X_LOW:      rd_mux = st_reg.sx[7:0];   // see [R20]
      ADDR_Y_HIGH:     rd_mux = st_reg.sy[15:8];
      ADDR_Y_LOW:      rd_mux = st_reg.sy[7:0];
      ADDR_Z_HIGH:     rd_mux = st_reg.sz[15:8];
      ADDR_Z_LOW:      rd_mux = st_reg.sz[7:0];
      ADDR_IDENTITY:   rd_mux = PART_ID;
      ADDR_OPSTATE:    rd_mux = {6'h00, st_reg.mode};
      ADDR_X_OFF_HIGH: rd_mux = st_reg.off_x[OFFSET_W-1:OFF_HIGH_LSB];
      ADDR_X_OFF_LOW:  rd_mux = off_low(st_reg.off_x);  // see [R17]
      ADDR_Y_OFF_HIGH: rd_mux = st_reg.off_y[OFFSET_W-1:OFF_HIGH_LSB];
      ADDR_Y_OFF_LOW:  rd_mux = off_low(st_reg.off_y);
      ADDR_Z_OFF_HIGH: rd_mux = st_reg.off_z[OFFSET_W-1:OFF_HIGH_LSB];
      ADDR_Z_OFF_LOW:  rd_mux = off_low(st_reg.off_z);
      ADDR_TEMP:       rd_mux = st_reg.temp;            // see [R18]
      ADDR_ACQ_CTRL:   rd_mux = st_reg.ctrl1;
      ADDR_CORR_CTRL:  rd_mux = st_reg.ctrl2;
      default:         rd_mux = UNMAPPED_BYTE;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next            = st_reg;
    st_next.sensor_rst = 1'b0;
    standby  = (st_reg.mode == MMC_STANDBY);
    rd_en    = rd_req && !ptr_load;
    wr_en    = wr_req && !ptr_load;
    read_x   = rd_en && st_reg.ptr == ADDR_X_HIGH;
    read_y   = rd_en && st_reg.ptr == ADDR_Y_HIGH;
    read_z   = rd_en && st_reg.ptr == ADDR_Z_HIGH;
    ctrl1_wr = wr_en && st_reg.ptr == ADDR_ACQ_CTRL;

    // Pointer: a load wins over a data strobe in the same cycle
    if (ptr_load)
      st_next.ptr = ptr_addr;
    else if (rd_req || wr_req)
      st_next.ptr = mmc_next_ptr(st_reg.ptr,
                                 st_reg.ctrl1[CR1_FAST_READ]); // see [R12] [R21]

    if (rd_en)
      st_next.rd_data = rd_mux;
    // Coherent set is frozen by the X high read
    if (read_x) begin  // see [R20]
      st_next.sx = st_reg.xs;
      st_next.sy = st_reg.ys;
      st_next.sz = st_reg.zs;
    end

    if (wr_en) begin
      unique case (st_reg.ptr)
        ADDR_X_OFF_HIGH:
          st_next.off_x[OFFSET_W-1:OFF_HIGH_LSB] = wr_data;
        ADDR_X_OFF_LOW:
          st_next.off_x[OFF_LOW_W-1:0] = wr_data[DATA_W-1:1];
        ADDR_Y_OFF_HIGH:
          st_next.off_y[OFFSET_W-1:OFF_HIGH_LSB] = wr_data;
        ADDR_Y_OFF_LOW:
          st_next.off_y[OFF_LOW_W-1:0] = wr_data[DATA_W-1:1];
        ADDR_Z_OFF_HIGH:
          st_next.off_z[OFFSET_W-1:OFF_HIGH_LSB] = wr_data;
        ADDR_Z_OFF_LOW:
          st_next.off_z[OFF_LOW_W-1:0] = wr_data[DATA_W-1:1];
        ADDR_ACQ_CTRL: begin
          if (standby)
            st_next.ctrl1 = wr_data;                 // see [R11]
          else begin
            st_next.ctrl1[CR1_ACTIVE]  = wr_data[CR1_ACTIVE];  // see [R14]
            st_next.ctrl1[CR1_TRIGGER] = wr_data[CR1_TRIGGER]; // see [R23]
          end
        end
        ADDR_CORR_CTRL: begin
          if (standby)
            st_next.ctrl2 = wr_data;                 // see [R14] [R8]
        end
        default: ;
      endcase
    end

    // Trigger self-clears after its measurement; a write wins
    if (meas_done && st_reg.ctrl1[CR1_TRIGGER] && !ctrl1_wr)
      st_next.ctrl1[CR1_TRIGGER] = 1'b0;             // see [R5] [R7]

    // Fresh samples; read-only data never clears on mode change
    if (meas_done) begin                             // see [R13]
      st_next.xs   = corrected(x_field, st_reg.off_x,
                               st_reg.ctrl2[CR2_RAW]);
      st_next.ys   = corrected(y_field, st_reg.off_y,
                               st_reg.ctrl2[CR2_RAW]);
      st_next.zs   = corrected(z_field, st_reg.off_z,
                               st_reg.ctrl2[CR2_RAW]);
      st_next.temp = temp_field;
    end

    // Per-axis flags: reads clear, a new measurement sets (set wins)
    if (read_x) begin
      st_next.flags[FLG_X_NEW] = 1'b0;
      st_next.flags[FLG_X_OVR] = 1'b0;
    end
    if (read_y) begin
      st_next.flags[FLG_Y_NEW] = 1'b0;
      st_next.flags[FLG_Y_OVR] = 1'b0;
    end
    if (read_z) begin
      st_next.flags[FLG_Z_NEW] = 1'b0;
      st_next.flags[FLG_Z_OVR] = 1'b0;
    end
    if (meas_done) begin
      st_next.flags[FLG_X_OVR] = st_reg.flags[FLG_X_NEW];
      st_next.flags[FLG_Y_OVR] = st_reg.flags[FLG_Y_NEW];
      st_next.flags[FLG_Z_OVR] = st_reg.flags[FLG_Z_NEW];
      st_next.flags[FLG_X_NEW] = 1'b1;
      st_next.flags[FLG_Y_NEW] = 1'b1;
      st_next.flags[FLG_Z_NEW] = 1'b1;
    end

    // Combined flags clear only once every axis high byte is read
    if (meas_done) begin
      st_next.flags[FLG_ALL_NEW] = 1'b1;
      st_next.flags[FLG_ALL_OVR] = st_reg.flags[FLG_ALL_OVR] |
        st_reg.flags[FLG_X_NEW] | st_reg.flags[FLG_Y_NEW] |
        st_reg.flags[FLG_Z_NEW];
    end else if (!st_next.flags[FLG_X_NEW] && !st_next.flags[FLG_Y_NEW] &&
                 !st_next.flags[FLG_Z_NEW]) begin    // see [R19]
      st_next.flags[FLG_ALL_NEW] = 1'b0;
      st_next.flags[FLG_ALL_OVR] = 1'b0;
    end

    // Interrupt level: raised with the combined flag
    if (meas_done)
      st_next.irq = 1'b1;                            // see [R1] [R22]
    else if (read_x || !st_next.flags[FLG_ALL_NEW])
      st_next.irq = 1'b0;                            // see [R2]

    st_next.sensor_rst = meas_start & st_reg.ctrl2[CR2_AUTO_RST]; // see [R8]
    st_next.mode       = mmc_decode_mode(st_next.ctrl1);  // see [R4] [R6]
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_reg      <= '0;                             // see [R15]
      st_reg.mode <= MMC_STANDBY;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data            = st_reg.rd_data;
  assign new_sample_irq     = st_reg.irq;
  assign sensor_reset_pulse = st_reg.sensor_rst;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence rd_x_s;
    rd_req && !ptr_load && st_reg.ptr == ADDR_X_HIGH && !meas_done;
  endsequence
  sequence rd_y_s;
    rd_req && !ptr_load && st_reg.ptr == ADDR_Y_HIGH && !meas_done;
  endsequence
  sequence rd_z_s;
    rd_req && !ptr_load && st_reg.ptr == ADDR_Z_HIGH && !meas_done;
  endsequence

  irq_follows_a: // see [R1]
    assert property (@(posedge core_clk) disable iff (reset)
      new_sample_irq |-> st_reg.flags[FLG_ALL_NEW])
    else $error("interrupt high without combined new-data flag");

  irq_clear_a: // see [R2]
    assert property (@(posedge core_clk) disable iff (reset)
      rd_x_s |=> !new_sample_irq)
    else $error("interrupt stayed high after X high read");

  irq_level_a: // see [R22]
    assert property (@(posedge core_clk) disable iff (reset)
      new_sample_irq && !rd_req |=> new_sample_irq)
    else $error("interrupt dropped without a clearing read");

  standby_idle_a: // see [R4]
    assert property (@(posedge core_clk) disable iff (reset)
      !$past(run) |-> !meas_done)
    else $error("measurement completed while in standby");

  single_return_a: // see [R5]
    assert property (@(posedge core_clk) disable iff (reset)
      meas_done && st_reg.ctrl1[CR1_TRIGGER] &&
      !st_reg.ctrl1[CR1_ACTIVE] && !wr_req
      |=> !st_reg.ctrl1[CR1_TRIGGER] && st_reg.mode == MMC_STANDBY)
    else $error("triggered measurement did not return to standby");

  ptr_normal_a: // see [R12]
    assert property (@(posedge core_clk) disable iff (reset)
      rd_req && !ptr_load && !st_reg.ctrl1[CR1_FAST_READ] &&
      st_reg.ptr == ADDR_X_HIGH |=> st_reg.ptr == ADDR_X_LOW)
    else $error("pointer did not step by one");

  ptr_fast_a: // see [R21]
    assert property (@(posedge core_clk) disable iff (reset)
      rd_req && !ptr_load && st_reg.ctrl1[CR1_FAST_READ] &&
      st_reg.ptr == ADDR_Z_HIGH |=> st_reg.ptr == ADDR_IDENTITY)
    else $error("fast read did not skip the low byte");

  ctrl_protect_a: // see [R14]
    assert property (@(posedge core_clk) disable iff (reset)
      wr_req && !ptr_load && st_reg.ptr == ADDR_CORR_CTRL &&
      st_reg.mode != MMC_STANDBY |=> $stable(st_reg.ctrl2))
    else $error("control write accepted outside standby");

  ctrl1_protect_a: // see [R23]
    assert property (@(posedge core_clk) disable iff (reset)
      wr_req && !ptr_load && st_reg.ptr == ADDR_ACQ_CTRL &&
      st_reg.mode != MMC_STANDBY
      |=> st_reg.ctrl1[DATA_W-1:CR1_FAST_READ] ==
          $past(st_reg.ctrl1[DATA_W-1:CR1_FAST_READ]))
    else $error("protected acquisition bits changed outside standby");

  all_clear_a: // see [R19]
    assert property (@(posedge core_clk) disable iff (reset)
      rd_x_s ##1 rd_y_s ##1 rd_z_s |=> !st_reg.flags[FLG_ALL_NEW])
    else $error("combined flag not cleared after all high reads");

  snapshot_a: // see [R20]
    assert property (@(posedge core_clk) disable iff (reset)
      rd_x_s |=> st_reg.sy == $past(st_reg.ys))
    else $error("sample set not refreshed by X high read");

endmodule // mmc_measure_control

/* verification/mmc_host_model.sv */
// Host model: register port master that services new_sample_irq.
// Assumes the block samples its register port on rising core_clk.
`timescale 1ns/1ps
module mmc_host_model (
  // Clock
  core_clk,
  // Register port
  ptr_load, ptr_addr, rd_req, rd_data, wr_req, wr_data,
  // Interrupt
  new_sample_irq
);
  input  wire logic       core_clk;
  output logic            ptr_load;
  output logic [7:0]      ptr_addr;
  output logic            rd_req;
  input  wire logic [7:0] rd_data;
  output logic            wr_req;
  output logic [7:0]      wr_data;
  input  wire logic       new_sample_irq;
  logic [7:0] got [$];
  initial begin
    ptr_load = 1'b0;
    ptr_addr = 8'h00;
    rd_req = 1'b0;
    wr_req = 1'b0;
    wr_data = 8'h00;
  end
  // Released lines show the inverse of their last value
  task automatic point(input logic [7:0] a);
    ptr_load = 1'b1;
    ptr_addr = a;
    @(posedge core_clk);
    #1;
    ptr_load = 1'b0;
    ptr_addr = ~a;
  endtask
  task automatic burst(input logic [7:0] a, input int n);
    point(a);
    got.delete();
    rd_req = 1'b1;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      got.push_back(rd_data);
    end
    rd_req = 1'b0;
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    point(a);
    wr_req = 1'b1;
    wr_data = d;
    @(posedge core_clk);
    #1;
    wr_req = 1'b0;
    wr_data = ~d;
  endtask
  // Arm automatic sensor resets before starting
  task automatic start(input logic [7:0] c1);
    write(8'h11, 8'h80);
    write(8'h10, c1);
  endtask
  task automatic wait_irq(input int lim, output int w);
    w = 0;
    while (new_sample_irq !== 1'b1 && w < lim) begin
      @(posedge core_clk);
      #1;
      w++;
    end
  endtask
  task automatic service(input int lim, output int w);
    wait_irq(lim, w);
    burst(8'h01, 6);
  endtask
endmodule // mmc_host_model

/* verification/test_mmc_measure_control.sv */
// Self-checking bench for the measurement control block.
// Assumes a shortened base period so runs stay short.
`timescale 1ns/1ps
module test_mmc_measure_control;
  import mmc_pkg::*;
  localparam int B = 20;
  // Identity value is arbitrary
  localparam logic [7:0] PID = 8'h3c;
  typedef struct { logic [7:0] a, d, e; } mmc_row_t;
  mmc_row_t rows [8] = '{'{8'h0d, 8'ha5, 8'ha5}, '{8'h0e, 8'h81, 8'h80},
    '{8'h0d, 8'h00, 8'h00}, '{8'h0e, 8'h00, 8'h00}, '{8'h07, 8'hff, PID},
    '{8'h00, 8'hff, 8'h00}, '{8'h12, 8'hff, 8'h00}, '{8'h11, 8'ha0, 8'ha0}};
  logic [7:0] zero_regs [10] = '{8'h00, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
    8'h0d, 8'h0e, 8'h10, 8'h11};
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic ptr_load, rd_req, wr_req, sensor_reset_pulse, new_sample_irq;
  logic [7:0] ptr_addr, rd_data, wr_data, temp_field;
  logic [15:0] x_field, y_field, z_field;
  logic [47:0] s;
  int fails = 0, comparisons = 0, cycles = 0, pulses = 0, w, p;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (sensor_reset_pulse === 1'b1) pulses++;
    if (cycles == 4000) begin
      fails++;
      report_and_stop();
    end
  end
  mmc_measure_control #(.BASE_CYC(B), .PART_ID(PID)) u_mmc_measure_control (
    .core_clk(core_clk), .reset(reset), .ptr_load(ptr_load),
    .ptr_addr(ptr_addr), .rd_req(rd_req), .rd_data(rd_data), .wr_req(wr_req),
    .wr_data(wr_data), .x_field(x_field), .y_field(y_field),
    .z_field(z_field), .temp_field(temp_field),
    .sensor_reset_pulse(sensor_reset_pulse), .new_sample_irq(new_sample_irq));
  mmc_host_model u_mmc_host_model (.core_clk(core_clk), .ptr_load(ptr_load),
    .ptr_addr(ptr_addr), .rd_req(rd_req), .rd_data(rd_data),
    .wr_req(wr_req), .wr_data(wr_data), .new_sample_irq(new_sample_irq));
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    u_mmc_host_model.burst(a, 1);
    chk8(n, e, u_mmc_host_model.got[0]);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    x_field = 16'h12a4;
    y_field = 16'hfe31;
    z_field = 16'h0457;
    temp_field = 8'he7;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    foreach (zero_regs[i]) rd("reset", zero_regs[i], 8'h00);
    foreach (rows[i]) begin
      u_mmc_host_model.write(rows[i].a, rows[i].d);
      rd("row", rows[i].a, rows[i].e);
    end
    s = {x_field, y_field, z_field};
    u_mmc_host_model.start(8'h01);
    u_mmc_host_model.service(3 * B, w);
    chk1("cont_irq", 1'b1, w < 3 * B);
    for (int i = 0; i < 6; i++)
      chk8("sample", s[47-8*i -: 8], u_mmc_host_model.got[i]);
    chk1("irq_clear", 1'b0, new_sample_irq);
    rd("mode_cont", 8'h08, 8'h02);
    u_mmc_host_model.write(8'h10, 8'h05);
    rd("ctrl1_lock", 8'h10, 8'h01);
    u_mmc_host_model.write(8'h11, 8'h00);
    rd("ctrl2_lock", 8'h11, 8'h80);
    u_mmc_host_model.write(8'h10, 8'h00);
    rd("x_high", 8'h01, s[47:40]);
    x_field = 16'h7e01;
    y_field = 16'h8c02;
    z_field = 16'h3303;
    repeat (60) @(posedge core_clk);
    #1;
    chk1("standby_irq", 1'b0, new_sample_irq);
    u_mmc_host_model.write(8'h10, 8'h04);
    u_mmc_host_model.burst(8'h01, 4);
    for (int i = 0; i < 3; i++)
      chk8("fast", s[47-16*i -: 8], u_mmc_host_model.got[i]);
    chk8("fast_id", PID, u_mmc_host_model.got[3]);
    s = {x_field, y_field, z_field};
    p = pulses;
    u_mmc_host_model.write(8'h10, 8'h1a);
    u_mmc_host_model.wait_irq(6 * B, w);
    chk1("single_time", 1'b1, w >= 4 * B && w <= 4 * B + 4);
    repeat (4) @(posedge core_clk);
    #1;
    chk1("irq_level", 1'b1, new_sample_irq);
    rd("flags_all", 8'h00, 8'h0f);
    rd("x_high2", 8'h01, s[47:40]);
    chk1("irq_drop", 1'b0, new_sample_irq);
    rd("flags_x", 8'h00, 8'h0e);
    rd("y_high", 8'h03, s[31:24]);
    rd("z_high", 8'h05, s[15:8]);
    rd("flags_none", 8'h00, 8'h00);
    rd("x_low", 8'h02, s[39:32]);
    rd("temp", 8'h0f, temp_field);
    rd("trig_clear", 8'h10, 8'h18);
    rd("mode_standby", 8'h08, 8'h00);
    chk1("auto_reset", 1'b1, pulses > 0);
    chk1("one_start", 1'b1, pulses == p + 1);
    u_mmc_host_model.start(8'hc9);
    u_mmc_host_model.wait_irq(30 * B, w);
    chk1("slow_time", 1'b1, w >= 26 * B && w <= 26 * B + 4);
    rd("slow_x", 8'h01, s[47:40]);
    u_mmc_host_model.write(8'h10, 8'h0b);
    u_mmc_host_model.wait_irq(3 * B, w);
    chk1("hurry_time", 1'b1, w <= B + 4);
    rd("resume", 8'h10, 8'hc9);
    reset = 1'b1;
    @(posedge core_clk);
    #1 reset = 1'b0;
    chk1("reset_irq", 1'b0, new_sample_irq);
    rd("reset_ctrl1", 8'h10, 8'h00);
    report_and_stop();
  end
endmodule // test_mmc_measure_control
